// ---- core/srd_defs.svh ----
// Shared timing, field and protocol constants for the serial EEPROM read engine
`ifndef SRD_DEFS_SVH
`define SRD_DEFS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define SRD_CLK_NS 100
`define SRD_SPIKE_NS 100
// Spike filter: a level must outlast this many cycles to count
`define SRD_FILT_CYC ((`SRD_SPIKE_NS + `SRD_CLK_NS - 1) / `SRD_CLK_NS)
`define SRD_TWR_MS 10
// Longest write cycle, rounded down to whole cycles
`define SRD_TWR_CYC ((`SRD_TWR_MS * 1000000) / `SRD_CLK_NS)
`define SRD_SCL_PERIOD_NS 10000
// Master quarter bit time; four quarters give one serial clock period
`define SRD_QTR_CYC ((`SRD_SCL_PERIOD_NS / 4 + `SRD_CLK_NS - 1) / `SRD_CLK_NS)

// ****************************************************************
// Addressing byte layout
// ****************************************************************
`define SRD_ID_MSB 7
`define SRD_ID_LSB 4
`define SRD_SEL_MSB 3
`define SRD_SEL_LSB 1
`define SRD_RW_BIT 0
`define SRD_BITS 8
`define SRD_PAGE_BITS 3
`define SRD_TYPE_ID_DEF 4'h5

`endif

// ---- core/srd_if.sv ----
// Two-wire link between the bus master and the EEPROM device
`timescale 1ns/1ps
`default_nettype none

interface srd_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // Open-drain wired-AND: either party pulling low wins, else pulled up
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

`default_nettype wire

// ---- core/srd_master.sv ----
// Bus master end: makes the serial clock and runs write, poll and read transfers
`timescale 1ns/1ps
`include "srd_defs.svh"
`default_nettype none

module srd_master import srd_pkg::*; #(
  parameter logic [3:0] TYPE_ID = `SRD_TYPE_ID_DEF, // Arbitrary value
  parameter int QTR_CYC = `SRD_QTR_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  srd_if.master bus,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire srd_cmd_t cmd_kind_i,
  input wire logic [2:0] cmd_sel_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [8:0] cmd_len_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic done_o,
  output logic nack_o
);

  // ****************************************************************
  // Data line synchroniser and quarter-bit timer
  // ****************************************************************
  logic sda1_q;
  logic sda_s_q;
  logic [7:0] tck_q;
  srd_op_t op_q;
  srd_ph_t ph_q;
  srd_cmd_t kind_q;
  logic [1:0] q_q;
  logic [3:0] bi_q;
  logic [7:0] sh_q;
  logic [8:0] len_q;
  logic [2:0] sel_q;
  logic [7:0] addr_q;
  logic [7:0] data_q;
  logic ack_q;
  logic bad_q;
  logic scl_q;
  logic oe_q;
  logic rdy_q;
  logic rdv_q;
  logic [7:0] rdd_q;
  logic done_q;
  logic nack_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sda1_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda1_q <= bus.sda;
      sda_s_q <= sda1_q;
    end
  end

  wire logic tick;
  wire logic launch;
  wire logic rx;
  wire logic more;
  wire logic bit_val;
  wire logic [7:0] dev_byte;

  assign tick = (op_q != OP_IDLE) && (tck_q == 8'(QTR_CYC - 1));
  assign launch = cmd_valid_i && rdy_q;
  assign rx = (ph_q == PH_READ);
  assign more = (len_q > 9'h001);
  assign dev_byte = {TYPE_ID, sel_q, ph_q == PH_DEVR};
  // Level placed on the data line in the second, clock-low quarter
  assign bit_val = (op_q == OP_START) ? 1'b1 :
                   (op_q == OP_STOP) ? 1'b0 :
                   (bi_q == 4'(`SRD_BITS)) ? (rx ? !more : 1'b1) :
                   (rx ? 1'b1 : sh_q[7]);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || tick || op_q == OP_IDLE) begin
      tck_q <= 8'h00;
    end else begin
      tck_q <= tck_q + 8'h01;
    end
  end

  // ****************************************************************
  // Bit and transaction sequencer
  // ****************************************************************
  // Data moves one quarter after the clock falls, so no edge overlaps
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      op_q <= OP_IDLE;
      ph_q <= PH_DEVW;
      kind_q <= CMD_POLL;
      q_q <= 2'h3;
      bi_q <= 4'h0;
      sh_q <= 8'h00;
      len_q <= 9'h000;
      sel_q <= 3'h0;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      ack_q <= 1'b1;
      bad_q <= 1'b0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      rdy_q <= 1'b1;
      rdv_q <= 1'b0;
      rdd_q <= 8'h00;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      rdv_q <= 1'b0;
      done_q <= 1'b0;
      if (launch) begin
        rdy_q <= 1'b0;
        op_q <= OP_START;
        q_q <= 2'h0; // All four START quarters must run
        kind_q <= cmd_kind_i;
        ph_q <= (cmd_kind_i == CMD_CUR_READ) ? PH_DEVR : PH_DEVW;
        sel_q <= cmd_sel_i;
        addr_q <= cmd_addr_i;
        data_q <= cmd_data_i;
        len_q <= cmd_len_i;
        bad_q <= 1'b0;
      end else if (tick) begin
        q_q <= q_q + 2'h1;
        unique case (q_q)
          2'h0: oe_q <= !bit_val;
          2'h1: scl_q <= 1'b1;
          2'h2: begin
            if (op_q == OP_START) begin
              oe_q <= 1'b1;
            end else if (op_q == OP_STOP) begin
              oe_q <= 1'b0;
            end else if (bi_q == 4'(`SRD_BITS)) begin
              ack_q <= sda_s_q;
            end else begin
              sh_q <= {sh_q[6:0], sda_s_q};
            end
          end
          2'h3: begin
            scl_q <= 1'b0;
            if (op_q == OP_START) begin
              op_q <= OP_BYTE;
              bi_q <= 4'h0;
              sh_q <= dev_byte;
            end else if (op_q == OP_STOP) begin
              op_q <= OP_IDLE;
              scl_q <= 1'b1;
              rdy_q <= 1'b1;
              done_q <= 1'b1;
              nack_q <= bad_q;
            end else if (bi_q != 4'(`SRD_BITS)) begin
              bi_q <= bi_q + 4'h1;
            end else begin
              bi_q <= 4'h0;
              if (!rx && ack_q) begin
                bad_q <= 1'b1;
                op_q <= OP_STOP;
              end else begin
                unique case (ph_q)
                  PH_DEVW: begin
                    if (kind_q == CMD_POLL) begin
                      op_q <= OP_STOP;
                    end else begin
                      ph_q <= PH_WORD;
                      sh_q <= addr_q;
                    end
                  end
                  PH_WORD: begin
                    if (kind_q == CMD_WRITE) begin
                      ph_q <= PH_DATA;
                      sh_q <= data_q;
                    end else begin
                      ph_q <= PH_DEVR;
                      op_q <= OP_START;
                    end
                  end
                  PH_DATA: op_q <= OP_STOP;
                  PH_DEVR: ph_q <= PH_READ;
                  PH_READ: begin
                    rdv_q <= 1'b1;
                    rdd_q <= sh_q;
                    len_q <= len_q - 9'h001;
                    if (!more) begin
                      op_q <= OP_STOP;
                    end
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  assign bus.scl = scl_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = oe_q;
  assign cmd_ready_o = rdy_q;
  assign rd_valid_o = rdv_q;
  assign rd_data_o = rdd_q;
  assign done_o = done_q;
  assign nack_o = nack_q;

endmodule

`default_nettype wire

// ---- core/srd_pkg.sv ----
// Types shared by both ends of the serial EEPROM link
`default_nettype none

package srd_pkg;

  // ****************************************************************
  // Device-side state (Gray along idle, address, word, write, read)
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DEV   = 3'h1,
    ST_WORD  = 3'h3,
    ST_WDATA = 3'h2,
    ST_READ  = 3'h6
  } srd_sst_t;

  // ****************************************************************
  // Master bus operations and transaction phases
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_IDLE  = 2'h0,
    OP_START = 2'h1,
    OP_BYTE  = 2'h3,
    OP_STOP  = 2'h2
  } srd_op_t;

  typedef enum logic [2:0] {
    PH_DEVW = 3'h0,
    PH_WORD = 3'h1,
    PH_DATA = 3'h3,
    PH_DEVR = 3'h2,
    PH_READ = 3'h6
  } srd_ph_t;

  typedef enum logic [1:0] {
    CMD_POLL      = 2'h0,
    CMD_WRITE     = 2'h1,
    CMD_CUR_READ  = 2'h2,
    CMD_RAND_READ = 2'h3
  } srd_cmd_t;

endpackage

`default_nettype wire

// ---- core/srd_slave.sv ----
// EEPROM device end: filtered two-wire slave with polling, write and reads
//
// How it works
// - No address acknowledge while write cycle busy.
// - Master polls with START plus addressing byte.
// - Read is write with direction bit one.
// - Address counter points past last accessed location.
// - Read address acked, then counter byte shifted out.
// - Master ends reads with no-ack then STOP.
// - Dummy write loads word address, no memory write.
// - Repeated read addressing returns byte just loaded.
// - Master ack advances counter, sends next byte.
// - Counter wraps 255 to 0 during reads.
// - Pulses up to 100 ns are filtered out.
// - Check type, select inputs; bit zero direction.
// - Receiver pulls data low on ninth clock.
// - START/STOP are data edges while clock high.
// - Internal write cycle ends within 10 ms.
`timescale 1ns/1ps
`include "srd_defs.svh"
`default_nettype none

module srd_slave import srd_pkg::*; #(
  parameter logic [3:0] TYPE_ID = `SRD_TYPE_ID_DEF, // Arbitrary value
  parameter int WR_CYC = `SRD_TWR_CYC,
  parameter int FILT_CYC = `SRD_FILT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  srd_if.slave bus,
  input wire logic [2:0] device_select_inputs_i,
  output logic wr_busy_o
);

  localparam int WW = $clog2(WR_CYC + 1);

  // ****************************************************************
  // Input synchronisers and spike filters
  // ****************************************************************
  logic [1:0] raw;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [2:0] dsel1_q;
  logic [2:0] dsel_q;
  logic flt_q [2];
  logic [3:0] fcnt_q [2];

  assign raw = {bus.scl, bus.sda};

  // Two flops per pin; idle bus is high so reset to ones
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      dsel1_q <= 3'h0;
      dsel_q <= 3'h0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      dsel1_q <= device_select_inputs_i; // Select pins may be driven from outside
      dsel_q <= dsel1_q;
    end
  end

  // A new level is taken only after it holds past the spike width
  generate
    for (genvar i = 0; i < 2; i++) begin : g_flt
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          flt_q[i] <= 1'b1;
          fcnt_q[i] <= 4'h0;
        end else if (s2_q[i] == flt_q[i]) begin
          fcnt_q[i] <= 4'h0;
        end else if (fcnt_q[i] == 4'(FILT_CYC)) begin
          flt_q[i] <= s2_q[i];
          fcnt_q[i] <= 4'h0;
        end else begin
          fcnt_q[i] <= fcnt_q[i] + 4'h1;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Bus event detection
  // ****************************************************************
  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;
  wire logic scl_rise;
  wire logic scl_fall;
  wire logic start_ev;
  wire logic stop_ev;

  assign scl_f = flt_q[1];
  assign sda_f = flt_q[0];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // Both lines pass the same filter delay, so their order is kept
  assign scl_rise = scl_f && !scl_p_q;
  assign scl_fall = !scl_f && scl_p_q;
  assign start_ev = scl_f && scl_p_q && sda_p_q && !sda_f;
  assign stop_ev = scl_f && scl_p_q && !sda_p_q && sda_f;

  // ****************************************************************
  // Byte engine state
  // ****************************************************************
  srd_sst_t st_q;
  logic [3:0] cnt_q;
  logic ackph_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic oe_q;
  logic [7:0] addr_q;
  logic mack_q;
  logic wrote_q;
  logic busy_q;
  logic [WW-1:0] wcnt_q;
  logic [7:0] mem_q [256];

  wire logic byte_done;
  wire logic dev_match;
  wire logic [7:0] rd_byte;
  wire logic wr_en;

  // Eighth bit has been clocked in and the clock has gone low again
  assign byte_done = scl_fall && !ackph_q && (cnt_q == 4'(`SRD_BITS)) && !start_ev && !stop_ev;
  // Identifier and select bits must match; a busy part stays silent
  assign dev_match = (sh_q[`SRD_ID_MSB:`SRD_ID_LSB] == TYPE_ID)
                  && (sh_q[`SRD_SEL_MSB:`SRD_SEL_LSB] == dsel_q)
                  && !busy_q;
  assign rd_byte = mem_q[addr_q];
  assign wr_en = byte_done && (st_q == ST_WDATA);

  // Main sequencer: START and STOP take priority over any bit
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ackph_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      oe_q <= 1'b0;
      addr_q <= 8'h00;
      mack_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= ST_DEV;
      cnt_q <= 4'h0;
      ackph_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (stop_ev) begin
      st_q <= ST_IDLE;
      ackph_q <= 1'b0;
      oe_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (st_q != ST_IDLE) begin
      if (scl_rise) begin
        if (ackph_q) begin
          mack_q <= !sda_f;
        end else begin
          sh_q <= {sh_q[6:0], sda_f};
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (scl_fall && ackph_q) begin
        // End of the ninth clock
        ackph_q <= 1'b0;
        cnt_q <= 4'h0;
        if (st_q == ST_READ && mack_q) begin
          tx_q <= {rd_byte[6:0], 1'b1};
          oe_q <= !rd_byte[7];
          addr_q <= addr_q + 8'h01;
        end else begin
          oe_q <= 1'b0;
          if (st_q == ST_READ) begin
            st_q <= ST_IDLE;
          end
        end
      end else if (byte_done) begin
        ackph_q <= 1'b1;
        unique case (st_q)
          ST_DEV: begin
            if (dev_match) begin
              oe_q <= 1'b1;
              mack_q <= 1'b1;
              st_q <= sh_q[`SRD_RW_BIT] ? ST_READ : ST_WORD;
            end else begin
              ackph_q <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
          ST_WORD: begin
            oe_q <= 1'b1;
            addr_q <= sh_q;
            st_q <= ST_WDATA;
          end
          ST_WDATA: begin
            oe_q <= 1'b1;
            // Writes stay inside the page so a long burst rolls over
            addr_q <= {addr_q[7:`SRD_PAGE_BITS], addr_q[`SRD_PAGE_BITS-1:0] + 3'h1};
            wrote_q <= 1'b1;
          end
          ST_READ: begin
            oe_q <= 1'b0;
            mack_q <= 1'b0;
          end
        endcase
      end else if (scl_fall && st_q == ST_READ) begin
        oe_q <= !tx_q[7]; // Next bit only while the clock is low
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // Array write; a dummy write never reaches here without a data byte
  always_ff @(posedge ref_clk_i) begin
    if (wr_en) begin
      mem_q[addr_q] <= sh_q;
    end
  end

  // ****************************************************************
  // Self-timed write cycle
  // ****************************************************************
  // Starts at STOP after data was taken; polls are refused meanwhile
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      wcnt_q <= '0;
    end else if (stop_ev && wrote_q) begin
      busy_q <= 1'b1;
      wcnt_q <= WW'(WR_CYC - 1);
    end else if (busy_q) begin
      if (wcnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        wcnt_q <= wcnt_q - WW'(1);
      end
    end
  end

  // Open drain: only ever pulls low
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = oe_q;
  assign wr_busy_o = busy_q;

endmodule

`default_nettype wire

// ---- sim/srd_link_assertions.sv ----
// Protocol checker watching the two-wire link between master and device
`timescale 1ns/1ps
`include "srd_defs.svh"
`default_nettype none

module srd_link_checker #(
  parameter logic [3:0] TYPE_ID = `SRD_TYPE_ID_DEF,
  parameter int WR_CYC = 2000
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic [2:0] device_select_inputs_i,
  input wire logic wr_busy_o
);
  // ****************************************************************
  // Raw link decode
  // ****************************************************************
  logic scl_q, sda_q, first_q, rd_q, wr_q, nack_q, seen_q;
  logic [3:0] bcnt_q;
  logic [7:0] sh_q;
  int busy_cnt_q;
  wire rise = scl && !scl_q;
  wire start_c = scl && scl_q && sda_q && !sda;
  wire stop_c = scl && scl_q && !sda_q && sda;
  wire ninth = rise && (bcnt_q == 4'h8);
  wire id_ok = (sh_q[7:4] == TYPE_ID) && (sh_q[3:1] == device_select_inputs_i);

  // Bit count and transfer mode; any START or STOP starts over
  always_ff @(posedge ref_clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rst_n_i || start_c || stop_c) begin
      bcnt_q <= 4'h0;
      first_q <= start_c;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (rise) begin
      bcnt_q <= ninth ? 4'h0 : bcnt_q + 4'h1;
      sh_q <= ninth ? sh_q : {sh_q[6:0], sda};
      first_q <= first_q && !ninth;
      rd_q <= (ninth && first_q) ? (sh_q[0] && !sda) : rd_q;
      wr_q <= (ninth && first_q) ? (!sh_q[0] && !sda) : wr_q;
      nack_q <= nack_q || (ninth && rd_q && sda);
    end
  end

  // Busy seen anywhere since START; a write cycle ending mid-byte is undecided
  always_ff @(posedge ref_clk_i) begin
    seen_q <= (!rst_n_i || start_c) ? 1'b0 : (seen_q || wr_busy_o);
    busy_cnt_q <= (!rst_n_i || !wr_busy_o) ? 0 : busy_cnt_q + 1;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_addr_ninth;
    ninth && first_q;
  endsequence
  sequence s_read_ninth;
    ninth && rd_q && !first_q;
  endsequence

  a_addr_ack: assert property (s_addr_ninth ##0 (id_ok && !seen_q && !wr_busy_o) |-> s_sda_oe)
    else $error("addressing byte not acknowledged");
  a_addr_refuse: assert property (s_addr_ninth ##0 (!id_ok || wr_busy_o) |-> !s_sda_oe)
    else $error("addressing byte acknowledged while busy or unmatched");
  a_word_ack: assert property ((ninth && wr_q && !first_q) |-> s_sda_oe)
    else $error("word address not acknowledged");
  a_rd_release: assert property (s_read_ninth |-> !s_sda_oe)
    else $error("device holds data in acknowledge slot");
  a_master_quiet: assert property ((rise && rd_q && !first_q && !nack_q && bcnt_q < 4'h8) |-> !m_sda_oe)
    else $error("master drives data during read byte");
  a_nack_idle: assert property (nack_q |-> !s_sda_oe)
    else $error("device drives after no acknowledge");
  a_edge_low: assert property ($rose(s_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  a_busy_bound: assert property (busy_cnt_q <= WR_CYC)
    else $error("write cycle too long");
  a_stop_quiet: assert property (stop_c |-> ##[1:8] !s_sda_oe)
    else $error("device still drives after STOP");
endmodule

`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench: master and device joined over the two-wire link
`timescale 1ns/1ps
`default_nettype none

module tb_top import srd_pkg::*; ;
  localparam int WRC = 2000;
  localparam int LIM = 20000;
  localparam logic [2:0] DEV_SEL = 3'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_ready, rd_valid, done, nack, wr_busy;
  srd_cmd_t cmd_kind;
  logic [2:0] cmd_sel;
  logic [7:0] cmd_addr, cmd_data, rd_data;
  logic [8:0] cmd_len;
  logic [16:0] lfsr_q = 17'h10ee2;
  logic [7:0] mem [0:255];
  int ptr, n_mismatch, num_checks, j, ofs;

  // 10 MHz system clock
  always #50 clk = ~clk;

  srd_if link ();
  srd_slave #(.WR_CYC(WRC)) i_srd_slave (.ref_clk_i(clk), .rst_n_i(rst_n), .bus(link.slave),
    .device_select_inputs_i(DEV_SEL), .wr_busy_o(wr_busy));
  srd_master #(.QTR_CYC(8)) i_srd_master (.ref_clk_i(clk), .rst_n_i(rst_n), .bus(link.master),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_kind_i(cmd_kind), .cmd_sel_i(cmd_sel),
    .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_len_i(cmd_len), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done), .nack_o(nack));
  srd_link_checker #(.WR_CYC(WRC)) i_srd_link_checker (.ref_clk_i(clk), .rst_n_i(rst_n), .scl(link.scl),
    .sda(link.sda), .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe), .device_select_inputs_i(DEV_SEL),
    .wr_busy_o(wr_busy));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [16:0] lfsr_next(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Model predicts bytes and refusal, then one command runs to its done pulse
  task automatic run(input srd_cmd_t k, input logic [7:0] a, input logic [7:0] d, input int n,
                     input logic [2:0] s, input logic exp_nack);
    logic [7:0] q [$];
    int i;
    if (!exp_nack && k == CMD_RAND_READ) ptr = a;
    if (!exp_nack && k == CMD_WRITE) begin
      mem[a] = d;
      ptr = (a & 8'hf8) | ((a + 1) & 7);
    end
    for (i = 0; i < n && !exp_nack && k[1]; i++) begin
      q.push_back(mem[ptr]);
      ptr = (ptr + 1) % 256;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_len <= 9'(n);
    cmd_sel <= s;
    for (i = 0; i < LIM && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i >= LIM) begin
      n_mismatch++;
      $display("[ERR] ready expected 1 seen 0");
      end_of_test();
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < LIM; i++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) chk_byte("read byte", (q.size() > 0) ? q.pop_front() : 8'hxx, rd_data);
      if (done === 1'b1) break;
    end
    if (i >= LIM) begin
      n_mismatch++;
      $display("[ERR] done expected 1 seen 0");
      end_of_test();
    end
    chk_flag("refused", exp_nack, nack);
    chk_byte("bytes left", 8'h00, 8'(q.size()));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    cmd_valid = 1'b0;
    cmd_kind = CMD_POLL;
    cmd_sel = 3'h0;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
    cmd_len = 9'h000;
    ptr = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Fill 252..255 and 0..3, last at 2 so the counter lands on 3
    for (j = 0; j < 8; j++) begin
      lfsr_q = lfsr_next(lfsr_q);
      run(CMD_WRITE, (j == 0) ? 8'h03 : 8'(j + 251), lfsr_q[7:0], 1, DEV_SEL, 1'b0);
      chk_flag("write busy", 1'b1, wr_busy);
      run(CMD_WRITE, (j == 0) ? 8'h03 : 8'(j + 251), lfsr_q[15:8], 1, DEV_SEL, 1'b1);
      repeat (WRC) @(posedge clk);
      chk_flag("write busy", 1'b0, wr_busy);
      run(CMD_POLL, 8'h00, 8'h00, 1, DEV_SEL, 1'b0);
    end
    run(CMD_CUR_READ, 8'h00, 8'h00, 1, DEV_SEL, 1'b0);
    run(CMD_RAND_READ, 8'hfd, 8'h00, 6, DEV_SEL, 1'b0);
    run(CMD_POLL, 8'h00, 8'h00, 1, DEV_SEL ^ 3'h1, 1'b1);
    run(CMD_CUR_READ, 8'h00, 8'h00, 1, DEV_SEL ^ 3'h4, 1'b1);
    run(CMD_CUR_READ, 8'h00, 8'h00, 1, DEV_SEL, 1'b0);
    run(CMD_RAND_READ, 8'hff, 8'h00, 1, DEV_SEL, 1'b0);
    run(CMD_CUR_READ, 8'h00, 8'h00, 3, DEV_SEL, 1'b0);
    // Random windows inside the written span
    for (j = 0; j < 4; j++) begin
      lfsr_q = lfsr_next(lfsr_q);
      ofs = lfsr_q[2:0];
      run(CMD_RAND_READ, 8'(252 + ofs), 8'h00, 1 + lfsr_q[8:4] % (8 - ofs), DEV_SEL, 1'b0);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
